// [hdl/gpp_port.sv]
// gpp_port: one 8-bit gpio port with interrupt logic, commit lock and pad control
// assumes: axi4-lite master on i_ref_clk; system logic tells which aperture an access used
// How it works
// - enabled pin interrupts merge into one output
// - edge status stays set until cleared
// - sense, both-edges, event bits choose trigger
// - mask bit 1 passes pin interrupt
// - raw status shows conditions regardless of mask
// - masked status shows only enabled conditions
// - writing one to clear location clears edge status
// - unmasked port b pin four triggers converter
// - alternate function hands pin to peripheral
// - protected bits need unlock and commit
// - protection only port b seven, debug pins
// - reset leaves pins undriven except debug
// - only selected aperture reaches the port
// - direction and open-drain bits select input, push-pull or open-drain
// - peripheral sets direction, needs digital enable
// - pad gets drive, pulls, slew, enables
// - read-only identification registers
// - direction zero input, one drives data
// - address bits nine to two mask data
`include "gpp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter gpp_port_t PORT = GPP_PORT_A
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // axi4-lite write
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // aperture select and the aperture of the current access
  input wire logic i_ahb_aperture_sel,
  input wire logic i_access_ahb,
  // pads and peripherals
  input wire gpp_pins_t i_pad_in,
  output var gpp_pins_t o_pad_out,
  output var gpp_pins_t o_pad_oe,
  input wire gpp_pins_t i_alt_out,
  input wire gpp_pins_t i_alt_oe,
  output var gpp_pins_t o_alt_in,
  // pad settings
  output var gpp_pins_t o_drive_2ma_select,
  output var gpp_pins_t o_drive_4ma_select,
  output var gpp_pins_t o_drive_8ma_select,
  output var gpp_pins_t o_pull_up_select,
  output var gpp_pins_t o_pull_down_select,
  output var gpp_pins_t o_slew_control_select,
  output var gpp_pins_t o_digital_enable,
  output var gpp_pins_t o_analog_mode_select,
  // interrupt and converter trigger
  output logic o_irq,
  output logic o_adc_trigger
);
  localparam gpp_pins_t PROT = (PORT == GPP_PORT_B) ? `GPP_PROT_B : (PORT == GPP_PORT_C) ? `GPP_PROT_C : 8'h00;
  localparam gpp_pins_t DBG_RST = (PORT == GPP_PORT_C) ? `GPP_DBG_RESET : 8'h00;

  gpp_irq_if irq ();
  gpp_pins_t data_reg, dir_reg, is_reg, ibe_reg, iev_reg, im_reg, afsel_reg, dr2_reg, dr4_reg, dr8_reg;
  gpp_pins_t odr_reg, pur_reg, pdr_reg, slr_reg, den_reg, amsel_reg, cr_reg;
  logic locked_reg;
  logic aw_full_reg, w_full_reg, aw_ok_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_strb0_reg;
  logic wr_go, wr_en, rd_ok;
  gpp_pins_t masked, wr_mask, commit_ok, pin_view;
  logic [31:0] rd_next;

  // write address and data may arrive in either order
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `GPP_RESP_OKAY;
      aw_addr_reg <= 12'h000;
      aw_ok_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full_reg <= 1'b1;
        o_awready <= 1'b0;
        aw_addr_reg <= i_awaddr;
        aw_ok_reg <= (i_access_ahb == i_ahb_aperture_sel) && is_mapped(i_awaddr);
      end
      if (i_wvalid && o_wready) begin
        w_full_reg <= 1'b1;
        o_wready <= 1'b0;
        w_data_reg <= i_wdata;
        w_strb0_reg <= i_wstrb[0];
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= aw_ok_reg ? `GPP_RESP_OKAY : `GPP_RESP_DECERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end
  assign wr_go = aw_full_reg && w_full_reg && !o_bvalid;
  assign wr_en = wr_go && aw_ok_reg && w_strb0_reg;

  function automatic logic is_mapped(input logic [11:0] a);
    return (a[11:10] == `GPP_OFS_DATA_HI) || (a[11:2] >= `GPP_OFS_DIR >> 2 && a[11:2] <= `GPP_OFS_AFSEL >> 2)
      || (a[11:2] >= `GPP_OFS_DR2 >> 2 && a[11:2] <= `GPP_OFS_AMSEL >> 2)
      || (a[11:6] == `GPP_ID_PAGE && a[5:2] >= `GPP_ID_FIRST);
  endfunction
  function automatic logic wr_at(input logic [11:0] ofs);
    return wr_en && aw_addr_reg[11:2] == ofs[11:2];
  endfunction

  // data register, address bits select which pins a write touches
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_reg <= 8'h00;
    end else if (wr_en && aw_addr_reg[11:10] == `GPP_OFS_DATA_HI) begin
      data_reg <= (data_reg & ~aw_addr_reg[9:2]) | (w_data_reg[7:0] & aw_addr_reg[9:2]);
    end
  end

  // plain settings
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dir_reg <= 8'h00;
      is_reg <= 8'h00;
      ibe_reg <= 8'h00;
      iev_reg <= 8'h00;
      im_reg <= 8'h00;
      odr_reg <= 8'h00;
      pdr_reg <= 8'h00;
      slr_reg <= 8'h00;
      amsel_reg <= 8'h00;
    end else begin
      if (wr_at(`GPP_OFS_DIR)) dir_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_IS)) is_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_IBE)) ibe_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_IEV)) iev_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_IM)) im_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_ODR)) odr_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_PDR)) pdr_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_SLR)) slr_reg <= w_data_reg[7:0];
      if (wr_at(`GPP_OFS_AMSEL)) amsel_reg <= w_data_reg[7:0];
    end
  end

  // drive strength: selecting one strength drops the other two
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dr2_reg <= `GPP_DR2_RESET;
      dr4_reg <= 8'h00;
      dr8_reg <= 8'h00;
    end else if (wr_at(`GPP_OFS_DR2)) begin
      dr2_reg <= dr2_reg | w_data_reg[7:0];
      dr4_reg <= dr4_reg & ~w_data_reg[7:0];
      dr8_reg <= dr8_reg & ~w_data_reg[7:0];
    end else if (wr_at(`GPP_OFS_DR4)) begin
      dr2_reg <= dr2_reg & ~w_data_reg[7:0];
      dr4_reg <= dr4_reg | w_data_reg[7:0];
      dr8_reg <= dr8_reg & ~w_data_reg[7:0];
    end else if (wr_at(`GPP_OFS_DR8)) begin
      dr2_reg <= dr2_reg & ~w_data_reg[7:0];
      dr4_reg <= dr4_reg & ~w_data_reg[7:0];
      dr8_reg <= dr8_reg | w_data_reg[7:0];
    end
  end

  // lock and commit: only protected pins ever need both
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      locked_reg <= 1'b1;
      cr_reg <= ~PROT;
    end else begin
      if (wr_at(`GPP_OFS_LOCK)) locked_reg <= (w_data_reg != `GPP_LOCK_KEY);
      if (wr_at(`GPP_OFS_CR) && !locked_reg) cr_reg <= ~PROT | (w_data_reg[7:0] & PROT);
    end
  end
  assign commit_ok = ~PROT | (cr_reg & {8{!locked_reg}});
  assign wr_mask = commit_ok;

  // committed settings: alternate function, pull-up, digital enable
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      afsel_reg <= DBG_RST;
      pur_reg <= DBG_RST;
      den_reg <= DBG_RST;
    end else begin
      if (wr_at(`GPP_OFS_AFSEL)) afsel_reg <= (afsel_reg & ~wr_mask) | (w_data_reg[7:0] & wr_mask);
      if (wr_at(`GPP_OFS_PUR)) pur_reg <= (pur_reg & ~wr_mask) | (w_data_reg[7:0] & wr_mask);
      if (wr_at(`GPP_OFS_DEN)) den_reg <= (den_reg & ~wr_mask) | (w_data_reg[7:0] & wr_mask);
    end
  end

  // detector wiring; clear pulses straight from the write
  assign irq.sense = is_reg;
  assign irq.both = ibe_reg;
  assign irq.event_pol = iev_reg;
  assign irq.clr = wr_at(`GPP_OFS_ICR) ? w_data_reg[7:0] : 8'h00;
  assign masked = irq.raw & im_reg;

  gpp_irq_detect u_detect (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_pad_in(i_pad_in),
    .irq(irq.det)
  );

  // port interrupt and converter trigger
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
      o_adc_trigger <= 1'b0;
    end else begin
      o_irq <= |masked;
      o_adc_trigger <= (PORT == GPP_PORT_B) && masked[`GPP_ADC_BIT];
    end
  end

  // read view of the data register: software-driven outputs show stored bits, other pins show the pin only if digitally enabled
  assign pin_view = (dir_reg & ~afsel_reg & data_reg) | (~(dir_reg & ~afsel_reg) & irq.pin_sync & den_reg);
  always_comb begin
    rd_next = 32'h0000_0000;
    if (i_araddr[11:10] == `GPP_OFS_DATA_HI) begin
      rd_next[7:0] = pin_view & i_araddr[9:2];
    end else if (i_araddr[11:6] == `GPP_ID_PAGE) begin
      rd_next[7:0] = `GPP_ID_SEED ^ {4'h0, i_araddr[5:2]}; // arbitrary identification values
    end else begin
      unique case (i_araddr[11:2])
        `GPP_OFS_DIR >> 2: rd_next[7:0] = dir_reg;
        `GPP_OFS_IS >> 2: rd_next[7:0] = is_reg;
        `GPP_OFS_IBE >> 2: rd_next[7:0] = ibe_reg;
        `GPP_OFS_IEV >> 2: rd_next[7:0] = iev_reg;
        `GPP_OFS_IM >> 2: rd_next[7:0] = im_reg;
        `GPP_OFS_RIS >> 2: rd_next[7:0] = irq.raw;
        `GPP_OFS_MIS >> 2: rd_next[7:0] = masked;
        `GPP_OFS_AFSEL >> 2: rd_next[7:0] = afsel_reg;
        `GPP_OFS_DR2 >> 2: rd_next[7:0] = dr2_reg;
        `GPP_OFS_DR4 >> 2: rd_next[7:0] = dr4_reg;
        `GPP_OFS_DR8 >> 2: rd_next[7:0] = dr8_reg;
        `GPP_OFS_ODR >> 2: rd_next[7:0] = odr_reg;
        `GPP_OFS_PUR >> 2: rd_next[7:0] = pur_reg;
        `GPP_OFS_PDR >> 2: rd_next[7:0] = pdr_reg;
        `GPP_OFS_SLR >> 2: rd_next[7:0] = slr_reg;
        `GPP_OFS_DEN >> 2: rd_next[7:0] = den_reg;
        `GPP_OFS_LOCK >> 2: rd_next[0] = locked_reg;
        `GPP_OFS_CR >> 2: rd_next[7:0] = cr_reg;
        `GPP_OFS_AMSEL >> 2: rd_next[7:0] = amsel_reg;
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end
  assign rd_ok = (i_access_ahb == i_ahb_aperture_sel) && is_mapped(i_araddr);

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `GPP_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_ok ? rd_next : 32'h0000_0000;
      o_rresp <= rd_ok ? `GPP_RESP_OKAY : `GPP_RESP_DECERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  gpp_pad_ctrl u_pad (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_afsel(afsel_reg),
    .i_dir(dir_reg),
    .i_odr(odr_reg),
    .i_den(den_reg),
    .i_data(data_reg),
    .i_pin_sync(irq.pin_sync),
    .i_alt_out(i_alt_out),
    .i_alt_oe(i_alt_oe),
    .o_alt_in(o_alt_in),
    .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe)
  );

  // pad settings straight from their registers
  assign o_drive_2ma_select = dr2_reg;
  assign o_drive_4ma_select = dr4_reg;
  assign o_drive_8ma_select = dr8_reg;
  assign o_pull_up_select = pur_reg;
  assign o_pull_down_select = pdr_reg;
  assign o_slew_control_select = slr_reg;
  assign o_digital_enable = den_reg;
  assign o_analog_mode_select = amsel_reg;

  property p_irq_follow;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    ##1 o_irq == $past(|(irq.raw & im_reg));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("port interrupt not matching masked status");
  property p_mask_block;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (im_reg == 8'h00) |=> !o_irq;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked pin raised interrupt");
  property p_adc;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_adc_trigger |-> (PORT == GPP_PORT_B) && $past(im_reg[4]) && $past(irq.raw[4]);
  endproperty
  a_adc: assert property (p_adc) else $error("converter trigger without unmasked pin four");
  property p_commit;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (wr_at(`GPP_OFS_AFSEL) && locked_reg) |=> ((afsel_reg & PROT) == $past(afsel_reg & PROT));
  endproperty
  a_commit: assert property (p_commit) else $error("protected bit changed while locked");
  property p_aperture;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (wr_go && !aw_ok_reg) |=> (o_bvalid && o_bresp == `GPP_RESP_DECERR && dir_reg == $past(dir_reg));
  endproperty
  a_aperture: assert property (p_aperture) else $error("refused access not answered with error");
endmodule
`default_nettype wire

// [hdl/gpp_cfg.svh]
// gpp_cfg.svh: register offsets, reset values and fixed bit positions of the gpio port
// assumes: included by bare name from the gpp_port module only
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH
`define GPP_OFS_DATA_HI 2'h0
`define GPP_OFS_DIR 12'h400
`define GPP_OFS_IS 12'h404
`define GPP_OFS_IBE 12'h408
`define GPP_OFS_IEV 12'h40C
`define GPP_OFS_IM 12'h410
`define GPP_OFS_RIS 12'h414
`define GPP_OFS_MIS 12'h418
`define GPP_OFS_ICR 12'h41C
`define GPP_OFS_AFSEL 12'h420
`define GPP_OFS_DR2 12'h500
`define GPP_OFS_DR4 12'h504
`define GPP_OFS_DR8 12'h508
`define GPP_OFS_ODR 12'h50C
`define GPP_OFS_PUR 12'h510
`define GPP_OFS_PDR 12'h514
`define GPP_OFS_SLR 12'h518
`define GPP_OFS_DEN 12'h51C
`define GPP_OFS_LOCK 12'h520
`define GPP_OFS_CR 12'h524
`define GPP_OFS_AMSEL 12'h528
`define GPP_ID_PAGE 6'h3F
`define GPP_ID_FIRST 4'h4
`define GPP_ID_SEED 8'h5A
`define GPP_LOCK_KEY 32'h1ACC_E55D
`define GPP_PROT_B 8'h80
`define GPP_PROT_C 8'h0F
`define GPP_DBG_RESET 8'h0F
`define GPP_DR2_RESET 8'hFF
`define GPP_ADC_BIT 4
`define GPP_RESP_OKAY 2'h0
`define GPP_RESP_DECERR 2'h3
`endif

// [hdl/gpp_pkg.sv]
// gpp_pkg: shared types of the gpio port
// assumes: constants come from gpp_cfg.svh
package gpp_pkg;
  typedef logic [7:0] gpp_pins_t;
  typedef enum {GPP_PORT_A, GPP_PORT_B, GPP_PORT_C, GPP_PORT_D,
                GPP_PORT_E, GPP_PORT_F, GPP_PORT_G, GPP_PORT_H} gpp_port_t;
endpackage

// [hdl/gpp_irq_if.sv]
// gpp_irq_if: trigger settings and status between the register file and the detector
// assumes: one register file and one detector on the same clock
`timescale 1ns/10ps
`default_nettype none
interface gpp_irq_if;
  import gpp_pkg::*;
  gpp_pins_t sense;
  gpp_pins_t both;
  gpp_pins_t event_pol;
  gpp_pins_t clr;
  gpp_pins_t raw;
  gpp_pins_t pin_sync;
  modport ctl (output sense, output both, output event_pol, output clr, input raw, input pin_sync);
  modport det (input sense, input both, input event_pol, input clr, output raw, output pin_sync);
endinterface
`default_nettype wire

// [hdl/gpp_irq_detect.sv]
// gpp_irq_detect: pin synchroniser and per-pin edge or level detection
// assumes: pad inputs may be asynchronous; clears are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module gpp_irq_detect
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // pads and settings
  input wire gpp_pins_t i_pad_in,
  gpp_irq_if.det irq
);
  gpp_pins_t sync1_reg;
  gpp_pins_t sync2_reg;
  gpp_pins_t prev_reg;
  gpp_pins_t raw_reg;
  gpp_pins_t hit;
  gpp_pins_t rise;
  gpp_pins_t fall;

  // two-stage synchroniser plus one older sample
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      sync1_reg <= i_pad_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // per-pin trigger decode and status
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_comb begin
      if (irq.sense[i]) begin
        hit[i] = (sync2_reg[i] == irq.event_pol[i]);
      end else if (irq.both[i]) begin
        hit[i] = rise[i] | fall[i];
      end else begin
        hit[i] = irq.event_pol[i] ? rise[i] : fall[i];
      end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        raw_reg[i] <= 1'b0;
      end else if (irq.sense[i]) begin
        raw_reg[i] <= hit[i];
      end else begin
        raw_reg[i] <= hit[i] | (raw_reg[i] & ~irq.clr[i]);
      end
    end
  end
  assign irq.raw = raw_reg;
  assign irq.pin_sync = sync2_reg;

  property p_edge_hold;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!irq.sense[0] && raw_reg[0] && !irq.clr[0]) |=> raw_reg[0];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge status lost without clear");
  property p_edge_clr;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!irq.sense[1] && irq.clr[1] && !hit[1]) |=> !raw_reg[1];
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("clear did not drop status");
  property p_rise;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!irq.sense[0] && !irq.both[0] && irq.event_pol[0] && sync2_reg[0] && !prev_reg[0]) |=> raw_reg[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge not caught");
  property p_level;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    irq.sense[2] |=> (raw_reg[2] == ($past(sync2_reg[2]) == $past(irq.event_pol[2])));
  endproperty
  a_level: assert property (p_level) else $error("level status not following pin");
endmodule
`default_nettype wire

// [hdl/gpp_pad_ctrl.sv]
// gpp_pad_ctrl: registered pad drive for software or alternate function control
// assumes: peripheral outputs are synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module gpp_pad_ctrl
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // settings
  input wire gpp_pins_t i_afsel,
  input wire gpp_pins_t i_dir,
  input wire gpp_pins_t i_odr,
  input wire gpp_pins_t i_den,
  input wire gpp_pins_t i_data,
  input wire gpp_pins_t i_pin_sync,
  // peripheral side
  input wire gpp_pins_t i_alt_out,
  input wire gpp_pins_t i_alt_oe,
  output var gpp_pins_t o_alt_in,
  // pad side
  output var gpp_pins_t o_pad_out,
  output var gpp_pins_t o_pad_oe
);
  gpp_pins_t val;
  gpp_pins_t drv;

  // source select: peripheral ignores direction, software uses it
  assign val = (i_afsel & i_alt_out) | (~i_afsel & i_data);
  assign drv = (i_afsel & i_alt_oe) | (~i_afsel & i_dir);

  // open drain only pulls low; nothing drives without digital enable
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pad_out <= 8'h00;
      o_pad_oe <= 8'h00;
      o_alt_in <= 8'h00;
    end else begin
      o_pad_out <= val & ~i_odr;
      o_pad_oe <= i_den & drv & ~(i_odr & val);
      o_alt_in <= i_pin_sync & i_den & i_afsel;
    end
  end

  property p_od;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_afsel[0] && i_den[0] && i_dir[0] && i_odr[0] && i_data[0]) |=> (!o_pad_oe[0] && !o_pad_out[0]);
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_alt;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_afsel[0] && i_den[0] && !i_odr[0] && i_alt_oe[0]) |=> (o_pad_oe[0] && o_pad_out[0] == $past(i_alt_out[0]));
  endproperty
  a_alt: assert property (p_alt) else $error("peripheral not driving pad");
endmodule
`default_nettype wire

// [bench/gpp_pad_model.sv]
// gpp_pad_model: pins and the outside sources that drive them
// assumes: level changes come from the bench between edges
`timescale 1ns/10ps
`default_nettype none
module gpp_pad_model
  import gpp_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // outside level and port drive
  input wire gpp_pins_t i_level,
  input wire gpp_pins_t i_pad_out,
  input wire gpp_pins_t i_pad_oe,
  output var gpp_pins_t o_pad_in
);
  // driven pins show the port, others hold the source level
  always_ff @(posedge i_ref_clk) begin
    o_pad_in <= (i_pad_oe & i_pad_out) | (~i_pad_oe & i_level);
  end
endmodule
`default_nettype wire

// [bench/tb_gpp_port.sv]
// tb_gpp_port: self-checking bench of one gpio port
// assumes: port b instance, axi4-lite master in this module
`timescale 1ns/10ps
`default_nettype none
module tb_gpp_port;
  import gpp_pkg::*;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d;} gpp_row_t;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic sel = 0, ahb = 0, ok_a, ok_w, hit;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rdata;
  logic [1:0] rsp, bresp, rresp;
  logic awrdy, wrdy, bv, arrdy, rv, irq, adc;
  gpp_pins_t lvl = 8'h02, pin, pout, poe, aout = 0, aoe = 0, d8, den, amsel;
  int err_count = 0, n_tests = 0, cyc = 0;
  gpp_row_t rows[14] = '{'{0, 12'h500, 32'h0000_00FF}, '{0, 12'h520, 32'h0000_0001},
    '{0, 12'h420, 32'h0000_0000}, '{0, 12'h524, 32'h0000_007F}, '{0, 12'hFE0, 32'h0000_0052},
    '{1, 12'h404, 32'h0000_0004}, '{1, 12'h408, 32'h0000_0002}, '{1, 12'h40C, 32'h0000_0005},
    '{1, 12'h410, 32'h0000_0007}, '{0, 12'h40C, 32'h0000_0005}, '{1, 12'h414, 32'h0000_00FF},
    '{0, 12'h414, 32'h0000_0000}, '{1, 12'h508, 32'h0000_0001}, '{0, 12'h500, 32'h0000_00FE}};
  gpp_port #(.PORT(GPP_PORT_B)) i_gpp_port (.i_ref_clk(clk), .i_reset_n(rst_n), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awrdy), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrdy),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arrdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr),
    .i_ahb_aperture_sel(sel), .i_access_ahb(ahb), .i_pad_in(pin), .o_pad_out(pout),
    .o_pad_oe(poe), .i_alt_out(aout), .i_alt_oe(aoe), .o_alt_in(), .o_drive_2ma_select(),
    .o_drive_4ma_select(), .o_drive_8ma_select(d8), .o_pull_up_select(), .o_pull_down_select(),
    .o_slew_control_select(), .o_digital_enable(den), .o_analog_mode_select(amsel), .o_irq(irq),
    .o_adc_trigger(adc));
  gpp_pad_model i_gpp_pad_model (.i_ref_clk(clk), .i_level(lvl), .i_pad_out(pout),
    .i_pad_oe(poe), .o_pad_in(pin));
  // clock and hang limit; the port clock runs from the start
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chkr(input logic [1:0] g, input logic [1:0] e);
    chk({30'h0, g}, {30'h0, e});
  endtask
  // axi4-lite write: hold each channel until its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(negedge clk);
      ok_a = awv & awrdy; ok_w = wv & wrdy; hit = bv; rsp = bresp;
      @(posedge clk);
      if (ok_a) awv <= 0;
      if (ok_w) wv <= 0;
    end while (!hit);
    br <= 0;
    @(posedge clk);
  endtask
  // axi4-lite read
  task automatic rd(input logic [11:0] a);
    ara <= a; arv <= 1; rr <= 1;
    do begin
      @(negedge clk);
      ok_a = arv & arrdy; hit = rv; rsp = rresp; rdat = rdata;
      @(posedge clk);
      if (ok_a) arv <= 0;
    end while (!hit);
    rr <= 0;
    @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    // reset values, trigger setup, read-only status
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a);
        chk(rdat, rows[i].d);
      end
    end
    chk({24'h0, d8}, 32'h0000_0001);
    $display("table done");
    // pin0 rises, pin1 falls on both-edges
    lvl <= 8'h01;
    repeat (6) @(posedge clk);
    rd(12'h414); chk(rdat, 32'h0000_0003);
    rd(12'h418); chk(rdat, 32'h0000_0003);
    chk({31'h0, irq}, 1);
    wr(12'h41C, 32'h0000_0001); rd(12'h414); chk(rdat, 32'h0000_0002);
    wr(12'h41C, 32'h0000_0002); rd(12'h414); chk(rdat, 32'h0000_0000);
    chk({31'h0, irq}, 0);
    // level on pin2 resists clearing, mask hides it
    lvl <= 8'h05;
    repeat (6) @(posedge clk);
    wr(12'h41C, 32'h0000_0004); rd(12'h414); chk(rdat, 32'h0000_0004);
    wr(12'h410, 32'h0000_0003); rd(12'h418); chk(rdat, 32'h0000_0000);
    rd(12'h414); chk(rdat, 32'h0000_0004);
    chk({31'h0, irq}, 0);
    // pin four falling edge, unmasked, after analog mode is set
    wr(12'h528, 32'h0000_0010);
    chk({24'h0, amsel}, 32'h0000_0010);
    wr(12'h410, 32'h0000_0010);
    lvl <= 8'h15;
    repeat (4) @(posedge clk);
    lvl <= 8'h05;
    repeat (6) @(posedge clk);
    chk({31'h0, adc}, 1);
    chk({31'h0, irq}, 1);
    $display("irq done");
    // aperture and unmapped refusals
    ahb <= 1; rd(12'h414); chkr(rsp, 2'h3); chk(rdat, 0);
    sel <= 1; rd(12'h414); chkr(rsp, 2'h0);
    sel <= 0; ahb <= 0; rd(12'h600); chkr(rsp, 2'h3);
    // masked data write, pad drive, alternate function
    wr(12'h400, 32'h0000_00FF); wr(12'h51C, 32'h0000_00FF); wr(12'h098, 32'h0000_00EB);
    rd(12'h3FC); chk(rdat, 32'h0000_0022);
    chk({24'h0, poe}, 32'h0000_007F);
    chk({24'h0, den}, 32'h0000_007F);
    chk({24'h0, pout}, 32'h0000_0022);
    aout <= 8'h01; aoe <= 8'h01; wr(12'h420, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk({24'h0, pout}, 32'h0000_0023);
    $display("pads done");
    // reset in mid-run
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk({24'h0, poe}, 0);
    chk({24'h0, den}, 0);
    rd(12'h51C); chk(rdat, 0);
    $display("reset done");
    end_sim();
  end
endmodule
`default_nettype wire
